/* rtl/pwm_regs.vh */
`ifndef PWM_REGS_VH
`define PWM_REGS_VH
// Time base modes
`define TB_MODE_W          2
`define TB_MODE_FREE       2'h0
`define TB_MODE_SINGLE     2'h1
`define TB_MODE_UPDOWN     2'h2
// Count direction encodings
`define DIR_UP             1'b0
`define DIR_DOWN           1'b1
// Parameter defaults and reset values
`define PWM_WIDTH_DEF      16
`define PWM_CHANNELS_DEF   3
`define COUNT_RESET        16'h0000
`endif

/* rtl/pwm_channel.v */
`default_nettype none
`include "pwm_regs.vh"
module pwm_channel #(
  parameter WIDTH = `PWM_WIDTH_DEF
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_arst_n,
  input  wire             i_ce,
  // Time base view
  input  wire             i_run,
  input  wire             i_center,
  input  wire             i_dir,
  input  wire [WIDTH-1:0] i_count,
  input  wire [WIDTH-1:0] i_period,
  // Duty and output
  input  wire [WIDTH-1:0] i_duty,
  output reg              o_pwm
);
  reg pwm_nxt;

  always @* begin
    pwm_nxt = o_pwm;
    if (i_duty == {WIDTH{1'b0}}) begin
      pwm_nxt = 1'b0;
    end else if (i_center) begin
      if (i_duty == i_period) begin
        pwm_nxt = 1'b1;
      end else if (i_count == i_duty && i_dir == `DIR_DOWN) begin
        pwm_nxt = 1'b1;
      end else if (i_count == i_duty && i_dir == `DIR_UP) begin
        pwm_nxt = 1'b0;
      end
    end else begin
      if (i_duty > i_period) begin
        pwm_nxt = 1'b1;
      end else if (i_count == i_duty) begin
        pwm_nxt = 1'b0;
      end else if (i_count == {WIDTH{1'b0}}) begin
        pwm_nxt = 1'b1;
      end
    end
    if (!i_run) begin
      pwm_nxt = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pwm <= 1'b0;
    end else if (i_ce) begin
      o_pwm <= pwm_nxt;
    end
  end
endmodule // pwm_channel
`default_nettype wire

/* rtl/edge_center_aligned_pwm.v */
`default_nettype none
`include "pwm_regs.vh"
module edge_center_aligned_pwm #(
  parameter WIDTH    = `PWM_WIDTH_DEF,
  parameter CHANNELS = `PWM_CHANNELS_DEF
) (
  // Clock and reset
  input  wire                      i_clk,
  input  wire                      i_arst_n,
  input  wire                      i_ce,
  // Configuration
  input  wire                      i_enable,
  input  wire [`TB_MODE_W-1:0]     i_tb_mode,
  input  wire [WIDTH-1:0]          i_pwm_period_value,
  input  wire [CHANNELS*WIDTH-1:0] i_duty,
  // Status
  output reg  [WIDTH-1:0]          o_pwm_time_base_count,
  output reg                       o_count_direction_flag,
  output reg                       o_running,
  // PWM outputs
  output wire [CHANNELS-1:0]       o_pwm
);
  // One count step at the configured width
  localparam [WIDTH-1:0] COUNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  reg  [WIDTH-1:0] count_nxt;
  reg              dir_nxt;
  reg              running_nxt;
  reg              enable_d_r;
  reg  [WIDTH-1:0] free_count;
  reg  [WIDTH-1:0] single_count;
  reg              single_run;
  reg  [WIDTH-1:0] updown_count;
  reg              updown_dir;
  wire             center;
  wire             start;
  wire             launch;
  wire             top;
  wire             bottom;

  // Count plus or minus one; callers keep the value inside zero to period
  function [WIDTH-1:0] step;
    input [WIDTH-1:0] value;
    input             down;
    begin
      if (down) begin
        step = value - COUNT_ONE;
      end else begin
        step = value + COUNT_ONE;
      end
    end
  endfunction

  // Only the three defined codes may run the time base
  function mode_valid;
    input [`TB_MODE_W-1:0] mode;
    begin
      case (mode)
        `TB_MODE_FREE:   mode_valid = 1'b1;
        `TB_MODE_SINGLE: mode_valid = 1'b1;
        `TB_MODE_UPDOWN: mode_valid = 1'b1;
        default:         mode_valid = 1'b0;
      endcase
    end
  endfunction

  // Greater-or-equal also catches a period lowered below the running count
  function at_top;
    input [WIDTH-1:0] value;
    input [WIDTH-1:0] limit;
    begin
      at_top = (value >= limit);
    end
  endfunction

  // Up/down selects center alignment, other modes edge alignment
  assign center = (i_tb_mode == `TB_MODE_UPDOWN);
  // Single-shot restarts only on a fresh enable edge
  assign start  = i_enable && !enable_d_r;
  // The unused mode code never starts, so it cannot set the running flag
  assign launch = mode_valid(i_tb_mode) && (start || i_tb_mode != `TB_MODE_SINGLE);
  assign top    = at_top(o_pwm_time_base_count, i_pwm_period_value);
  assign bottom = (o_pwm_time_base_count == {WIDTH{1'b0}});

  // Free-running: back to zero after the period value
  always @* begin
    if (top) begin
      free_count = `COUNT_RESET;
    end else begin
      free_count = step(o_pwm_time_base_count, `DIR_UP);
    end
  end

  // Single-shot: stops holding the last count so status shows completion
  always @* begin
    single_count = o_pwm_time_base_count;
    single_run   = 1'b1;
    if (top) begin
      single_run = 1'b0;
    end else begin
      single_count = step(o_pwm_time_base_count, `DIR_UP);
    end
  end

  // Up/down: turns at the period value and at zero
  always @* begin
    updown_dir   = o_count_direction_flag;
    updown_count = step(o_pwm_time_base_count, o_count_direction_flag);
    if (o_count_direction_flag == `DIR_UP && top) begin
      updown_dir   = `DIR_DOWN;
      updown_count = step(o_pwm_time_base_count, `DIR_DOWN);
    end else if (o_count_direction_flag == `DIR_DOWN && bottom) begin
      updown_dir   = `DIR_UP;
      updown_count = step(o_pwm_time_base_count, `DIR_UP);
    end
  end

  // Enable low clears the time base; a stopped time base waits for a valid start
  always @* begin
    count_nxt   = o_pwm_time_base_count;
    dir_nxt     = o_count_direction_flag;
    running_nxt = o_running;
    if (!i_enable) begin
      count_nxt   = `COUNT_RESET;
      dir_nxt     = `DIR_UP;
      running_nxt = 1'b0;
    end else if (!o_running) begin
      if (launch) begin
        running_nxt = 1'b1;
        count_nxt   = `COUNT_RESET;
        dir_nxt     = `DIR_UP;
      end
    end else begin
      case (i_tb_mode)
        `TB_MODE_FREE: begin
          count_nxt = free_count;
        end
        `TB_MODE_SINGLE: begin
          count_nxt   = single_count;
          running_nxt = single_run;
        end
        `TB_MODE_UPDOWN: begin
          count_nxt = updown_count;
          dir_nxt   = updown_dir;
        end
        default: begin
          count_nxt   = `COUNT_RESET;
          running_nxt = 1'b0;
        end
      endcase
    end
  end

  // Status outputs are the time base flops themselves
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pwm_time_base_count <= `COUNT_RESET;
    end else if (i_ce) begin
      o_pwm_time_base_count <= count_nxt;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count_direction_flag <= `DIR_UP;
    end else if (i_ce) begin
      o_count_direction_flag <= dir_nxt;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_running <= 1'b0;
    end else if (i_ce) begin
      o_running <= running_nxt;
    end
  end

  // Starts low, matching the idle enable, so reset gives no false start edge
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable_d_r <= 1'b0;
    end else if (i_ce) begin
      enable_d_r <= i_enable;
    end
  end

  // Channels compare the registered count, so outputs lag the count by one cycle
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      // Each channel takes its own slice of the packed duty bus
      wire [WIDTH-1:0] duty_w;
      assign duty_w = i_duty[g*WIDTH +: WIDTH];
      pwm_channel #(
        .WIDTH (WIDTH)
      ) u_chan (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_run    (o_running),
        .i_center (center),
        .i_dir    (o_count_direction_flag),
        .i_count  (o_pwm_time_base_count),
        .i_period (i_pwm_period_value),
        .i_duty   (duty_w),
        .o_pwm    (o_pwm[g])
      );
    end
  endgenerate
endmodule // edge_center_aligned_pwm
`default_nettype wire

/* verif/edge_center_aligned_pwm_sva.sv */
`default_nettype none
`include "pwm_regs.vh"
module edge_center_aligned_pwm_sva #(parameter WIDTH = 16, parameter CHANNELS = 3) (
  // Inputs of the block
  input wire logic                      i_clk, i_arst_n, i_ce, i_enable,
  input wire logic [1:0]                i_tb_mode,
  input wire logic [WIDTH-1:0]          i_pwm_period_value,
  input wire logic [CHANNELS*WIDTH-1:0] i_duty,
  // Outputs of the block
  input wire logic [WIDTH-1:0]          o_pwm_time_base_count,
  input wire logic                      o_count_direction_flag, o_running,
  input wire logic [CHANNELS-1:0]       o_pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  // Channel 0 only: the others share the same compare logic
  wire [WIDTH-1:0] c = o_pwm_time_base_count, p = i_pwm_period_value, d = i_duty[WIDTH-1:0];
  wire g = i_ce && i_enable && o_running;
  wire fr = g && i_tb_mode == `TB_MODE_FREE, ud = g && i_tb_mode == `TB_MODE_UPDOWN;
  wire sg = g && i_tb_mode == `TB_MODE_SINGLE, ed = fr || sg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_st; ed && c == 0 && d != 0 |=> o_pwm[0]; endproperty
  a_st: assert property (p_st) else $error("no set at start");
  property p_clr; ed && c == d && d <= p |=> !o_pwm[0]; endproperty
  a_clr: assert property (p_clr) else $error("no clear on match");
  property p_zero; g && d == 0 |=> !o_pwm[0]; endproperty
  a_zero: assert property (p_zero) else $error("zero duty active");
  property p_full; ed && d > p |=> o_pwm[0]; endproperty
  a_full: assert property (p_full) else $error("big duty inactive");
  property p_dn; ud && o_count_direction_flag && c == d && d != 0 |=> o_pwm[0]; endproperty
  a_dn: assert property (p_dn) else $error("no set on down match");
  property p_up; ud && !o_count_direction_flag && c == d && d != 0 && d != p |=> !o_pwm[0]; endproperty
  a_up: assert property (p_up) else $error("no clear on up match");
  property p_top; ud && d == p && d != 0 |=> o_pwm[0]; endproperty
  a_top: assert property (p_top) else $error("period duty inactive");
  property p_wrap; fr && c == p |=> c == 0; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period");
  property p_stop; sg && c >= p |=> !o_running; endproperty
  a_stop: assert property (p_stop) else $error("single shot did not stop");
  property p_turn; ud && !o_count_direction_flag && c >= p |=> o_count_direction_flag && c == $past(c) - 1'b1;
  endproperty
  a_turn: assert property (p_turn) else $error("no turn at period");
  c_fr: cover property (fr && c == p);
  c_ud: cover property (ud && o_count_direction_flag && c == 0);
  c_sg: cover property (sg && c == p);
endmodule // edge_center_aligned_pwm_sva
bind edge_center_aligned_pwm edge_center_aligned_pwm_sva #(.WIDTH(WIDTH), .CHANNELS(CHANNELS)) u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_enable(i_enable), .i_tb_mode(i_tb_mode),
  .i_pwm_period_value(i_pwm_period_value), .i_duty(i_duty), .o_pwm_time_base_count(o_pwm_time_base_count),
  .o_count_direction_flag(o_count_direction_flag), .o_running(o_running), .o_pwm(o_pwm));
`default_nettype wire

/* verif/edge_center_aligned_pwm_tb.sv */
`default_nettype none
`include "pwm_regs.vh"
module edge_center_aligned_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_arst_n, i_ce, i_enable, o_count_direction_flag, o_running, md, mr;
  logic [1:0]  i_tb_mode;
  logic [15:0] i_pwm_period_value, o_pwm_time_base_count, mc;
  logic [47:0] i_duty;
  logic [2:0]  o_pwm, mp, np;
  int          n_errors = 0;
  int          checked = 0;
  edge_center_aligned_pwm u_edge_center_aligned_pwm (
    .i_clk                  (i_clk),
    .i_arst_n               (i_arst_n),
    .i_ce                   (i_ce),
    .i_enable               (i_enable),
    .i_tb_mode              (i_tb_mode),
    .i_pwm_period_value     (i_pwm_period_value),
    .i_duty                 (i_duty),
    .o_pwm_time_base_count  (o_pwm_time_base_count),
    .o_count_direction_flag (o_count_direction_flag),
    .o_running              (o_running),
    .o_pwm                  (o_pwm)
  );
  initial begin
    i_clk = 0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(string s, logic [20:0] g, logic [20:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic f(logic [1:0] m, logic [15:0] c, d, p, logic dr, o);
    if (d == 0) return 1'h0;
    if (m == `TB_MODE_UPDOWN) return d == p ? 1'h1 : c == d ? dr : o;
    return d > p ? 1'h1 : c == d ? 1'h0 : c == 0 ? 1'h1 : o;
  endfunction
  // Own count model, compared every cycle; the unused mode code must stay stopped
  task automatic run(logic [1:0] m, logic [15:0] p, logic [47:0] d, bit gap);
    @(posedge i_clk) #1 i_enable = 0;
    @(posedge i_clk) #1 {i_tb_mode, i_pwm_period_value, i_duty, i_enable} = {m, p, d, 1'b1};
    {mc, md, mr, mp} = 0;
    for (int k = 0; k < 40; k++) begin
      i_ce = !gap || k % 5 != 2;
      @(posedge i_clk) #1;
      if (i_ce) begin
        for (int g = 0; g < 3; g++) np[g] = mr & f(m, mc, d[g*16+:16], p, md, mp[g]);
        if (k == 0) mr = m != 2'h3;
        else if (mr && m != `TB_MODE_UPDOWN) begin
          mr = m == `TB_MODE_FREE || mc != p;
          mc = mc == p ? (m == `TB_MODE_FREE ? 16'h0 : p) : mc + 16'h1;
        end else if (mr) begin
          if (mc == (md ? 16'h0 : p)) md = !md;
          mc = md ? mc - 16'h1 : mc + 16'h1;
        end
        mp = np;
      end
      chk("state", {o_pwm_time_base_count, o_count_direction_flag, o_running, o_pwm},
          {mc, md, mr, mp});
    end
  endtask
  initial begin
    {i_arst_n, i_ce, i_enable, i_tb_mode, i_pwm_period_value, i_duty} = 0;
    repeat (2) @(posedge i_clk);
    #1 {i_arst_n, i_ce} = 2'h3;
    run(`TB_MODE_FREE, 16'h5, {16'h0, 16'h3, 16'h6}, 0);
    run(`TB_MODE_FREE, 16'h5, {16'h2, 16'h1, 16'h5}, 1);
    run(`TB_MODE_SINGLE, 16'h4, {16'h5, 16'h2, 16'h0}, 0);
    run(`TB_MODE_UPDOWN, 16'h6, {16'h0, 16'h3, 16'h6}, 0);
    run(`TB_MODE_UPDOWN, 16'h6, {16'h2, 16'h5, 16'h1}, 1);
    run(2'h3, 16'h5, {16'h1, 16'h2, 16'h3}, 0);
    stop_test;
  end
  initial begin
    #20000;
    n_errors++;
    stop_test;
  end
endmodule // edge_center_aligned_pwm_tb
`default_nettype wire
